// ---- hdl/dlmb_pkg.sv ----
package dlmb_pkg;

  // ----------------------------------------------------------------
  // mode register addresses and field layout
  // ----------------------------------------------------------------
  localparam logic [5:0] LMR_ADDR    = 6'h02;
  localparam logic [5:0] SPC_ADDR    = 6'h0d;
  localparam int         RL_LSB      = 0;
  localparam int         WL_LSB      = 3;
  localparam int         WLS_BIT     = 6;
  localparam int         WLEV_BIT    = 7;
  localparam int         SETPOINT_WRITE_SELECT_BIT  = 6;
  localparam int         SETPOINT_OPERATE_SELECT_BIT  = 7;
  localparam logic [7:0] LMR_RESET   = 8'h00;
  localparam logic       SPC_RESET   = 1'b0;
  localparam int         LAT_W       = 6;

  // ----------------------------------------------------------------
  // burst geometry
  // ----------------------------------------------------------------
  localparam logic [4:0] LAST_BEAT16 = 5'h0f;
  localparam logic [4:0] LAST_BEAT32 = 5'h1f;

  // ----------------------------------------------------------------
  // latency tables, index is the three-bit code
  // ----------------------------------------------------------------
  localparam logic [5:0] RL_TAB_N [8] = '{6'h06, 6'h0a, 6'h0e, 6'h14,
                                          6'h18, 6'h1c, 6'h20, 6'h24};
  localparam logic [5:0] RL_TAB_I [8] = '{6'h06, 6'h0c, 6'h10, 6'h16,
                                          6'h1c, 6'h20, 6'h24, 6'h28};
  localparam logic [5:0] RTP_TAB  [8] = '{6'h08, 6'h08, 6'h08, 6'h08,
                                          6'h0a, 6'h0c, 6'h0e, 6'h10};
  localparam logic [5:0] WL_TAB_A [8] = '{6'h04, 6'h06, 6'h08, 6'h0a,
                                          6'h0c, 6'h0e, 6'h10, 6'h12};
  localparam logic [5:0] WL_TAB_B [8] = '{6'h04, 6'h08, 6'h0c, 6'h12,
                                          6'h12, 6'h12, 6'h12, 6'h12};

  // ----------------------------------------------------------------
  // link commands
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CMD_NOP = 3'b000,
    CMD_MRW = 3'b001,
    CMD_MRR = 3'b010,
    CMD_WR  = 3'b011,
    CMD_RD  = 3'b100,
    CMD_PRE = 3'b101
  } dlmb_cmd_t;

  // ----------------------------------------------------------------
  // controller software registers
  // ----------------------------------------------------------------
  localparam int         REG_AW   = 8;
  localparam logic [7:0] HR_CMD   = 8'h00;
  localparam logic [7:0] HR_COL   = 8'h04;
  localparam logic [7:0] HR_WDATA = 8'h08;
  localparam logic [7:0] HR_STAT  = 8'h0c;

endpackage

// ---- hdl/dlmb_if.sv ----
`timescale 1ns/1ps
interface dlmb_if #(parameter int DATA_W = 16);
  logic                cmd_valid;
  dlmb_pkg::dlmb_cmd_t cmd;
  logic [5:0]          ma;
  logic [7:0]          op;
  logic                bl32;
  logic [9:2]          col;
  logic                wvalid;
  logic [DATA_W-1:0]   wdata;
  logic                mrr_valid;
  logic [7:0]          mrr_data;

  modport host (output cmd_valid, cmd, ma, op, bl32, col, wvalid, wdata,
                input  mrr_valid, mrr_data);
  modport dev  (input  cmd_valid, cmd, ma, op, bl32, col, wvalid, wdata,
                output mrr_valid, mrr_data);
endinterface

// ---- hdl/dlmb_fifo.sv ----
`timescale 1ns/1ps
module dlmb_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input  wire logic             MCLK_IN,
  input  wire logic             RST_N_IN,
  input  wire logic             IN_VALID_IN,
  output logic                  IN_READY_OUT,
  input  wire logic [WIDTH-1:0] IN_DATA_IN,
  output logic                  OUT_VALID_OUT,
  input  wire logic             OUT_READY_IN,
  output logic [WIDTH-1:0]      OUT_DATA_OUT
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0]   FULL_CNT = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_ptr_q;
  logic [AW-1:0]    rd_ptr_q;
  logic [AW:0]      count_q;
  logic             push;
  logic             pop;

  assign IN_READY_OUT  = (count_q != FULL_CNT);
  assign OUT_VALID_OUT = (count_q != '0);
  assign OUT_DATA_OUT  = mem_q[rd_ptr_q];
  assign push          = IN_VALID_IN && IN_READY_OUT;
  assign pop           = OUT_VALID_OUT && OUT_READY_IN;

  always_ff @(posedge MCLK_IN) begin
    if (push) begin
      mem_q[wr_ptr_q] <= IN_DATA_IN;
    end
  end

  always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= (wr_ptr_q == LAST_PTR) ? '0 : wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= (rd_ptr_q == LAST_PTR) ? '0 : rd_ptr_q + 1'b1;
      end
      count_q <= count_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule

// ---- hdl/dlmb_host.sv ----
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
module dlmb_host #(
  parameter int DATA_W     = 16,
  parameter int FIFO_DEPTH = 8
) (
  input  wire logic                        MCLK_IN,
  input  wire logic                        RST_N_IN,
  input  wire logic                        READ_INVERSION_IN,
  input  wire logic [dlmb_pkg::REG_AW-1:0] REG_ADDR_IN,
  input  wire logic [31:0]                 REG_WDATA_IN,
  input  wire logic                        REG_WR_IN,
  input  wire logic                        REG_RD_IN,
  output logic [31:0]                      REG_RDATA_OUT,
  output logic                             WDATA_READY_OUT,
  dlmb_if.host                             LINK
);
  import dlmb_pkg::*;

  typedef enum logic [1:0] {
    H_IDLE  = 2'b00,
    H_WAIT  = 2'b01,
    H_BEATS = 2'b10
  } dlmb_hstate_t;

  dlmb_hstate_t      state_q;
  dlmb_cmd_t         pcmd_q;
  logic              pbl32_q, pend_q, refused_q, mrr_done_q, wrlev_q;
  logic [5:0]        pma_q;
  logic [7:0]        pop_q, mrr_q;
  logic [9:0]        col_q;
  logic [7:0]        shadow_q [2];
  logic              setpoint_write_select_q, setpoint_operate_select_q;
  logic [LAT_W-1:0]  wait_q, rtp_cnt_q, wl, rtp;
  logic [4:0]        beat_q;
  logic [DATA_W-1:0] fifo_data;
  logic              fifo_valid, sending, emit, launch, cmd_wr, stat_rd;
  logic [7:0]        act;
  dlmb_cmd_t         new_cmd;

  // ----------------------------------------------------------------
  // write data buffer
  // ----------------------------------------------------------------
  dlmb_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .MCLK_IN       (MCLK_IN),
    .RST_N_IN      (RST_N_IN),
    .IN_VALID_IN   (REG_WR_IN && (REG_ADDR_IN == HR_WDATA)),
    .IN_READY_OUT  (WDATA_READY_OUT),
    .IN_DATA_IN    (REG_WDATA_IN[DATA_W-1:0]),
    .OUT_VALID_OUT (fifo_valid),
    .OUT_READY_IN  (emit),
    .OUT_DATA_OUT  (fifo_data)
  );

  // ----------------------------------------------------------------
  // operating latencies from the shadow of the active set point
  // ----------------------------------------------------------------
  assign act     = shadow_q[setpoint_operate_select_q];
  assign wl      = act[WLS_BIT] ? WL_TAB_B[act[WL_LSB+:3]] : WL_TAB_A[act[WL_LSB+:3]];
  assign rtp     = RTP_TAB[act[RL_LSB+:3]];
  assign new_cmd = dlmb_cmd_t'(REG_WDATA_IN[2:0]);
  assign cmd_wr  = REG_WR_IN && (REG_ADDR_IN == HR_CMD);
  assign stat_rd = REG_RD_IN && (REG_ADDR_IN == HR_STAT);
  assign launch  = pend_q && (state_q == H_IDLE) && !((pcmd_q == CMD_PRE) && (rtp_cnt_q != '0));
  assign sending = ((state_q == H_WAIT) && (wait_q == 6'h01)) || (state_q == H_BEATS);
  assign emit    = sending && fifo_valid;

  // ----------------------------------------------------------------
  // command capture
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      pend_q    <= 1'b0;
      refused_q <= 1'b0;
      pcmd_q    <= CMD_NOP;
      pbl32_q   <= 1'b0;
      pma_q     <= 6'h00;
      pop_q     <= 8'h00;
      col_q     <= 10'h000;
    end else begin
      if (REG_WR_IN && (REG_ADDR_IN == HR_COL)) begin
        col_q <= REG_WDATA_IN[9:0];
      end
      if (launch) begin
        pend_q <= 1'b0;
      end
      if (cmd_wr) begin
        if (pend_q || (state_q != H_IDLE) || (wrlev_q && !((new_cmd == CMD_MRW) &&
            (REG_WDATA_IN[9:4] == LMR_ADDR) && !REG_WDATA_IN[10+WLEV_BIT]))) begin
          refused_q <= 1'b1;
        end else begin
          refused_q <= 1'b0;
          pend_q    <= 1'b1;
          pcmd_q    <= new_cmd;
          pbl32_q   <= REG_WDATA_IN[3];
          pma_q     <= REG_WDATA_IN[9:4];
          pop_q     <= REG_WDATA_IN[17:10];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // link command drive
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      LINK.cmd_valid <= 1'b0;
      LINK.cmd       <= CMD_NOP;
      LINK.ma        <= 6'h00;
      LINK.op        <= 8'h00;
      LINK.bl32      <= 1'b0;
      LINK.col       <= 8'h00;
    end else begin
      LINK.cmd_valid <= launch;
      if (launch) begin
        LINK.cmd  <= pcmd_q;
        LINK.ma   <= pma_q;
        LINK.op   <= pop_q;
        LINK.bl32 <= pbl32_q;
        LINK.col  <= (pcmd_q == CMD_WR) ?
                     {col_q[9:5], col_q[4] && !pbl32_q, 2'b00} : col_q[9:2];
      end
    end
  end

  // ----------------------------------------------------------------
  // shadow of device mode state
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      shadow_q[0] <= LMR_RESET;
      shadow_q[1] <= LMR_RESET;
      setpoint_write_select_q    <= SPC_RESET;
      setpoint_operate_select_q    <= SPC_RESET;
      wrlev_q     <= 1'b0;
    end else if (launch && (pcmd_q == CMD_MRW)) begin
      if (pma_q == LMR_ADDR) begin
        shadow_q[setpoint_write_select_q] <= pop_q;
        wrlev_q            <= pop_q[WLEV_BIT];
      end
      if (pma_q == SPC_ADDR) begin
        setpoint_write_select_q <= pop_q[SETPOINT_WRITE_SELECT_BIT];
        setpoint_operate_select_q <= pop_q[SETPOINT_OPERATE_SELECT_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // write burst timing and read-to-precharge count
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      state_q     <= H_IDLE;
      wait_q      <= 6'h00;
      rtp_cnt_q   <= 6'h00;
      beat_q      <= 5'h00;
      LINK.wvalid <= 1'b0;
      LINK.wdata  <= '0;
    end else begin
      LINK.wvalid <= emit;
      if (emit) begin
        LINK.wdata <= fifo_data;
      end
      if (launch && (pcmd_q == CMD_RD)) begin
        rtp_cnt_q <= rtp;
      end else if (rtp_cnt_q != '0) begin
        rtp_cnt_q <= rtp_cnt_q - 1'b1;
      end
      unique case (state_q)
        H_IDLE: begin
          if (launch && (pcmd_q == CMD_WR)) begin
            state_q <= H_WAIT;
            wait_q  <= wl;
            beat_q  <= 5'h00;
          end
        end
        H_WAIT: begin
          if (wait_q != 6'h01) begin
            wait_q <= wait_q - 1'b1;
          end else if (emit) begin
            state_q <= H_BEATS;
            beat_q  <= beat_q + 1'b1;
          end
        end
        H_BEATS: begin
          if (emit) begin
            beat_q <= beat_q + 1'b1;
            if (beat_q == (pbl32_q ? LAST_BEAT32 : LAST_BEAT16)) begin
              state_q <= H_IDLE;
            end
          end
        end
        default: state_q <= H_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // mode register read result and software read port
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      mrr_q         <= 8'h00;
      mrr_done_q    <= 1'b0;
      REG_RDATA_OUT <= 32'h0000_0000;
    end else begin
      if (LINK.mrr_valid) begin
        mrr_q      <= LINK.mrr_data;
        mrr_done_q <= 1'b1;
      end else if (stat_rd) begin
        mrr_done_q <= 1'b0;
      end
      REG_RDATA_OUT <= 32'h0000_0000;
      if (REG_RD_IN) begin
        unique case (REG_ADDR_IN)
          HR_CMD:  REG_RDATA_OUT <= {14'h0000, pop_q, pma_q, pbl32_q, pcmd_q};
          HR_COL:  REG_RDATA_OUT <= {22'h000000, col_q};
          HR_STAT: REG_RDATA_OUT <= {2'h0, rtp, 2'h0, wl, mrr_q, 2'h0, READ_INVERSION_IN,
                                     WDATA_READY_OUT, mrr_done_q, refused_q, wrlev_q,
                                     pend_q || (state_q != H_IDLE)};
          default: REG_RDATA_OUT <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule

// ---- hdl/dlmb_device.sv ----
`timescale 1ns/1ps
module dlmb_device #(
  parameter int DATA_W = 16
) (
  input  wire logic                       MCLK_IN,
  input  wire logic                       RST_N_IN,
  input  wire logic                       READ_INVERSION_IN,
  dlmb_if.dev                             LINK,
  output logic [dlmb_pkg::LAT_W-1:0]      READ_LATENCY_OUT,
  output logic [dlmb_pkg::LAT_W-1:0]      RTP_OUT,
  output logic [dlmb_pkg::LAT_W-1:0]      WRITE_LATENCY_OUT,
  output logic                            WRLEV_OUT,
  output logic                            SETPOINT_OP_OUT,
  output logic                            STORE_VALID_OUT,
  output logic [9:0]                      STORE_COL_OUT,
  output logic [DATA_W-1:0]               STORE_DATA_OUT
);
  import dlmb_pkg::*;

  typedef enum logic [1:0] {
    D_IDLE   = 2'b00,
    D_WRLEV  = 2'b01,
    D_WBURST = 2'b10
  } dlmb_dstate_t;

  dlmb_dstate_t state_q;
  logic [7:0]   lmr_q [2];
  logic         setpoint_write_select_q;
  logic         setpoint_operate_select_q;
  logic [9:2]   col_q;
  logic         bl32_q;
  logic [4:0]   beat_q;
  logic [7:0]   act;
  logic         accept;
  logic         mrw_lmr;
  logic         mrw_spc;
  logic         last_beat;

  // ----------------------------------------------------------------
  // command acceptance
  // ----------------------------------------------------------------
  // in write leveling, commands other than the leveling exit are dropped
  always_comb begin
    accept = 1'b0;
    if (LINK.cmd_valid) begin
      unique case (state_q)
        D_IDLE:   accept = 1'b1;
        D_WRLEV:  accept = (LINK.cmd == CMD_MRW) && (LINK.ma == LMR_ADDR) &&
                           !LINK.op[WLEV_BIT];
        D_WBURST: accept = 1'b0;
        default:  accept = 1'b0;
      endcase
    end
  end

  assign mrw_lmr = accept && (LINK.cmd == CMD_MRW) && (LINK.ma == LMR_ADDR);
  assign mrw_spc = accept && (LINK.cmd == CMD_MRW) && (LINK.ma == SPC_ADDR);

  // ----------------------------------------------------------------
  // set-point copies of the latency mode register
  // ----------------------------------------------------------------
  // only the write-selected copy takes the operand
  for (genvar sp = 0; sp < 2; sp++) begin : g_copy
    always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
        lmr_q[sp] <= LMR_RESET;
      end else if (mrw_lmr && (setpoint_write_select_q == 1'(sp))) begin
        lmr_q[sp] <= LINK.op;
      end
    end
  end

  // ----------------------------------------------------------------
  // set-point control
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      setpoint_write_select_q <= SPC_RESET;
      setpoint_operate_select_q <= SPC_RESET;
    end else if (mrw_spc) begin
      setpoint_write_select_q <= LINK.op[SETPOINT_WRITE_SELECT_BIT];
      setpoint_operate_select_q <= LINK.op[SETPOINT_OPERATE_SELECT_BIT];
    end
  end

  // ----------------------------------------------------------------
  // operating latencies
  // ----------------------------------------------------------------
  // only the operate-selected copy drives timing
  assign act = lmr_q[setpoint_operate_select_q];

  always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      READ_LATENCY_OUT  <= RL_TAB_N[0];
      RTP_OUT           <= RTP_TAB[0];
      WRITE_LATENCY_OUT <= WL_TAB_A[0];
      SETPOINT_OP_OUT   <= SPC_RESET;
    end else begin
      READ_LATENCY_OUT  <= READ_INVERSION_IN ? RL_TAB_I[act[RL_LSB+:3]]
                                             : RL_TAB_N[act[RL_LSB+:3]];
      RTP_OUT           <= RTP_TAB[act[RL_LSB+:3]];
      WRITE_LATENCY_OUT <= act[WLS_BIT] ? WL_TAB_B[act[WL_LSB+:3]]
                                        : WL_TAB_A[act[WL_LSB+:3]];
      SETPOINT_OP_OUT   <= setpoint_operate_select_q;
    end
  end

  // ----------------------------------------------------------------
  // mode register read answer
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      LINK.mrr_valid <= 1'b0;
      LINK.mrr_data  <= 8'h00;
    end else begin
      LINK.mrr_valid <= accept && (LINK.cmd == CMD_MRR);
      if (accept && (LINK.cmd == CMD_MRR)) begin
        if (LINK.ma == LMR_ADDR) begin
          LINK.mrr_data <= lmr_q[setpoint_write_select_q];
        end else if (LINK.ma == SPC_ADDR) begin
          LINK.mrr_data <= {setpoint_operate_select_q, setpoint_write_select_q, 6'h00};
        end else begin
          LINK.mrr_data <= 8'h00;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // mode state
  // ----------------------------------------------------------------
  assign last_beat = LINK.wvalid &&
                     (beat_q == (bl32_q ? LAST_BEAT32 : LAST_BEAT16));

  always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      state_q <= D_IDLE;
      col_q   <= 8'h00;
      bl32_q  <= 1'b0;
    end else begin
      unique case (state_q)
        D_IDLE: begin
          if (mrw_lmr && LINK.op[WLEV_BIT]) begin
            state_q <= D_WRLEV;
          end else if (accept && (LINK.cmd == CMD_WR)) begin
            state_q <= D_WBURST;
            col_q   <= LINK.col;
            bl32_q  <= LINK.bl32;
          end
        end
        D_WRLEV: begin
          if (mrw_lmr) begin
            state_q <= D_IDLE;
          end
        end
        D_WBURST: begin
          if (last_beat) begin
            state_q <= D_IDLE;
          end
        end
        default: state_q <= D_IDLE;
      endcase
    end
  end

  assign WRLEV_OUT = (state_q == D_WRLEV);

  // ----------------------------------------------------------------
  // write burst store sequence
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      beat_q          <= 5'h00;
      STORE_VALID_OUT <= 1'b0;
      STORE_COL_OUT   <= 10'h000;
      STORE_DATA_OUT  <= '0;
    end else begin
      STORE_VALID_OUT <= (state_q == D_WBURST) && LINK.wvalid;
      if (state_q != D_WBURST) begin
        beat_q <= 5'h00;
      end else if (LINK.wvalid) begin
        beat_q         <= beat_q + 1'b1;
        STORE_DATA_OUT <= LINK.wdata;
        // ascending beats from an aligned base
        STORE_COL_OUT  <= bl32_q ? {col_q[9:5], beat_q}
                                 : {col_q[9:5], col_q[4], beat_q[3:0]};
      end
    end
  end
endmodule

// ---- tb/dlmb_props.sv ----
`timescale 1ns/1ps
module dlmb_props
  import dlmb_pkg::*;
(
  input wire logic                MCLK_IN,
  input wire logic                RST_N_IN,
  input wire logic                cmd_valid,
  input wire dlmb_pkg::dlmb_cmd_t cmd,
  input wire logic [5:0]          ma,
  input wire logic [7:0]          op,
  input wire logic                bl32,
  input wire logic [9:2]          col,
  input wire logic                wvalid,
  input wire logic                mrr_valid
);
  logic [5:0] left_q;
  logic       lev_q;
  wire        wr_go = cmd_valid && cmd == CMD_WR;
  default clocking @(posedge MCLK_IN); endclocking
  default disable iff (!RST_N_IN);
  // beats still owed by the open write burst
  always_ff @(posedge MCLK_IN or negedge RST_N_IN)
    if (!RST_N_IN) left_q <= 6'h00;
    else if (wr_go) left_q <= bl32 ? 6'h20 : 6'h10;
    else if (wvalid && left_q != 6'h00) left_q <= left_q - 6'h01;
  always_ff @(posedge MCLK_IN or negedge RST_N_IN)
    if (!RST_N_IN) lev_q <= 1'b0;
    else if (cmd_valid && cmd == CMD_MRW && ma == LMR_ADDR) lev_q <= op[WLEV_BIT];
  property p_wr_col; wr_go |-> col[3:2] == 2'b00; endproperty
  a_wr_col: assert property (p_wr_col) else $error("write column bits 3:2 not zero");
  property p_wr32; wr_go && bl32 |-> !col[4]; endproperty
  a_wr32: assert property (p_wr32) else $error("32-beat write not aligned");
  property p_beats; wvalid |-> left_q != 6'h00; endproperty
  a_beats: assert property (p_beats) else $error("write beat outside burst");
  property p_busy; cmd_valid |-> left_q == 6'h00; endproperty
  a_busy: assert property (p_busy) else $error("command during write burst");
  property p_lev;
    cmd_valid && lev_q |-> cmd == CMD_MRW && ma == LMR_ADDR && !op[WLEV_BIT];
  endproperty
  a_lev: assert property (p_lev) else $error("command other than leveling exit");
  property p_mrr; mrr_valid |-> $past(cmd_valid && cmd == CMD_MRR); endproperty
  a_mrr: assert property (p_mrr) else $error("read answer without request");
  property p_rtp; cmd_valid && cmd == CMD_RD |=> !(cmd_valid && cmd == CMD_PRE) [*8]; endproperty
  a_rtp: assert property (p_rtp) else $error("precharge too soon after read");
  property p_wl; wr_go |=> !wvalid [*3]; endproperty
  a_wl: assert property (p_wl) else $error("write data before write latency");
endmodule

// ---- tb/test_dram_latency_mode_burst.sv ----
`timescale 1ns/1ps
module test_dram_latency_mode_burst;
  import dlmb_pkg::*;
  logic        clk, rst_n, inv, wr, rd, wrdy, lev, spo, sv;
  logic [7:0]  addr, o;
  logic [31:0] wd, rdata, s;
  logic [5:0]  rl, rtp, wl;
  logic [9:0]  scol, c;
  logic [15:0] sdat;
  logic [25:0] exp_q[$], got_q[$];
  int fail_count, samples_checked, seed, cyc, k, n, fw, fo, lv;
  int m[2];
  int rln[8] = '{6, 10, 14, 20, 24, 28, 32, 36};
  int rli[8] = '{6, 12, 16, 22, 28, 32, 36, 40};
  int rtpt[8] = '{8, 8, 8, 8, 10, 12, 14, 16};
  int wla[8] = '{4, 6, 8, 10, 12, 14, 16, 18};
  int wlb[8] = '{4, 8, 12, 18, 18, 18, 18, 18};
  dlmb_if #(.DATA_W(16)) dlmb_if_i ();
  dlmb_host dlmb_host_i (.MCLK_IN(clk), .RST_N_IN(rst_n), .READ_INVERSION_IN(inv),
    .REG_ADDR_IN(addr), .REG_WDATA_IN(wd), .REG_WR_IN(wr), .REG_RD_IN(rd),
    .REG_RDATA_OUT(rdata), .WDATA_READY_OUT(wrdy), .LINK(dlmb_if_i));
  dlmb_device dlmb_device_i (.MCLK_IN(clk), .RST_N_IN(rst_n), .READ_INVERSION_IN(inv),
    .LINK(dlmb_if_i), .READ_LATENCY_OUT(rl), .RTP_OUT(rtp), .WRITE_LATENCY_OUT(wl),
    .WRLEV_OUT(lev), .SETPOINT_OP_OUT(spo), .STORE_VALID_OUT(sv),
    .STORE_COL_OUT(scol), .STORE_DATA_OUT(sdat));
  dlmb_props dlmb_props_i (.MCLK_IN(clk), .RST_N_IN(rst_n),
    .cmd_valid(dlmb_if_i.cmd_valid), .cmd(dlmb_if_i.cmd), .ma(dlmb_if_i.ma),
    .op(dlmb_if_i.op), .bl32(dlmb_if_i.bl32), .col(dlmb_if_i.col),
    .wvalid(dlmb_if_i.wvalid), .mrr_valid(dlmb_if_i.mrr_valid));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (sv === 1'b1) got_q.push_back({scol, sdat});
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      $display("ERROR timeout expected idle seen hang");
      test_done;
    end
  end
  task automatic test_done;
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] e, logic [31:0] v);
    samples_checked++;
    if (v !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, e, v);
    end
  endtask
  task automatic wreg(logic [7:0] a, logic [31:0] d);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rreg(logic [7:0] a);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 s = rdata;
    @(posedge clk);
  endtask
  task automatic idle;
    repeat (6) @(posedge clk);
    for (int i = 0; i < 200; i++) begin
      rreg(HR_STAT);
      if (s[0] === 1'b0) break;
    end
  endtask
  task automatic cmd(dlmb_cmd_t t, logic b, logic [5:0] a, logic [7:0] p);
    wreg(HR_CMD, {14'h0000, p, a, b, t});
  endtask
  task automatic cl;
    int q, w;
    q = m[fo];
    w = q[6] ? wlb[q / 8 % 8] : wla[q / 8 % 8];
    chk("rl", inv ? rli[q % 8] : rln[q % 8], 32'(rl));
    chk("rtp", rtpt[q % 8], 32'(rtp));
    chk("wl", w, 32'(wl));
    chk("spo", fo, 32'(spo));
    rreg(HR_STAT);
    chk("stat wl", w, s[21:16]);
    chk("stat rtp", rtpt[q % 8], s[29:24]);
    chk("stat inv", inv, s[5]);
    chk("stat refused", 0, s[2]);
    chk("stat mrr done", 0, s[3]);
  endtask
  task automatic moderegister_write_cmd(logic [5:0] a, logic [7:0] p);
    cmd(CMD_MRW, 1'b0, a, p);
    idle;
    if (a == LMR_ADDR) begin
      m[fw] = p;
      lv = p[7];
    end else begin
      fw = p[6];
      fo = p[7];
    end
    chk("lev", lv, 32'(lev));
  endtask
  task automatic moderegister_read_cmd(logic [5:0] a, logic [7:0] e);
    cmd(CMD_MRR, 1'b0, a, 8'h00);
    repeat (6) @(posedge clk);
    rreg(HR_STAT);
    chk("mrr done", 1, s[3]);
    chk("mrr", e, s[15:8]);
  endtask
  task automatic push;
    logic [15:0] d;
    d = 16'($random(seed));
    exp_q.push_back({c | 10'(k), d});
    wreg(HR_WDATA, 32'(d));
    k++;
  endtask
  initial begin
    {rst_n, inv, wr, rd, addr, wd} = '0;
    seed = 93;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    cl;
    rreg(8'h10);
    chk("unmapped", 0, s);
    $display("defaults done");
    for (int i = 0; i < 16; i++) begin
      o = {1'b0, i[3] ^ i[0], 3'(7 - i), 3'(i)};
      inv <= i[3];
      moderegister_write_cmd(LMR_ADDR, o);
      cl;
      moderegister_read_cmd(LMR_ADDR, o);
    end
    $display("latency tables done");
    moderegister_write_cmd(SPC_ADDR, 8'h40);
    moderegister_write_cmd(LMR_ADDR, 8'h3f);
    cl;
    moderegister_read_cmd(LMR_ADDR, 8'h3f);
    moderegister_write_cmd(SPC_ADDR, 8'hc0);
    cl;
    moderegister_write_cmd(SPC_ADDR, 8'h80);
    moderegister_read_cmd(LMR_ADDR, 8'(m[0]));
    $display("setpoints done");
    moderegister_write_cmd(LMR_ADDR, 8'h80);
    rreg(HR_STAT);
    chk("lev stat", 1, s[1]);
    cmd(CMD_RD, 1'b0, 6'h00, 8'h00);
    rreg(HR_STAT);
    chk("refused", 1, s[2]);
    moderegister_write_cmd(LMR_ADDR, 8'h05);
    cl;
    cmd(CMD_RD, 1'b0, 6'h00, 8'h00);
    cmd(CMD_PRE, 1'b0, 6'h00, 8'h00);
    idle;
    $display("leveling done");
    for (int b = 0; b < 2; b++) begin
      n = b ? 32 : 16;
      c = 10'($random(seed)) & (b ? 10'h3e0 : 10'h3f0);
      k = 0;
      exp_q.delete();
      got_q.delete();
      while (wrdy === 1'b1 && k < n) push;
      chk("fifo fill", 8, k);
      wreg(HR_WDATA, 32'h0000ffff);
      wreg(HR_COL, 32'(c));
      rreg(HR_COL);
      chk("col", 32'(c), s);
      cmd(CMD_WR, b[0], 6'h00, 8'h00);
      while (k < n) begin
        if (wrdy === 1'b1) push;
        else @(posedge clk);
      end
      idle;
      chk("beats", n, got_q.size());
      foreach (exp_q[i]) chk("store", exp_q[i], got_q[i]);
      $display("burst %0d done", n);
    end
    test_done;
  end
endmodule
